// >>> dca_pkg.sv
// Shared constants for the double-data-rate command/address link.
// Assumes both ends run on one 100 MHz ref_clk and sample the link pins.
package dca_pkg;
   // ==========================================================
   // Header layout
   localparam int HDR_BYTES = 6;
   localparam int HDR_W = 48;
   localparam int BIT_RNW = 47;
   localparam int BIT_SPACE = 46;
   localparam int BIT_BURST = 45;
   localparam int ROW_HI = 44;
   localparam int ROW_LO = 16;
   localparam int COL_HI = 2;
   localparam int COL_LO = 0;
   localparam int ADDR_W = 32;
   localparam int WORD_W = 16;
   localparam int HALF_PAGE_WORDS = 8;
   localparam logic [2:0] HDR_LAST = 3'h5;
   // ==========================================================
   // Timing: host link clock half period in ref_clk cycles
   localparam int REF_NS = 10;
   localparam int LINK_HALF_NS = 60;
   localparam int LINK_HALF_CYC = (LINK_HALF_NS + REF_NS - 1) / REF_NS;
   // Read access latency in link clock cycles after header
   localparam int ACC_CLKS = 4;
   // ==========================================================
   // Device phases
   typedef enum logic [1:0] {DCA_IDLE, DCA_HDR, DCA_WAIT, DCA_DATA} dca_phase_t;
endpackage

// >>> dca_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
module dca_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];   // Storage
   logic [AW-1:0] wr_ff;               // Write index
   logic [AW-1:0] rd_ff;               // Read index
   logic [AW:0] cnt_ff;                // Fill level
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // Full only at DEPTH entries; level is one bit wider than the index
   assign in_ready = 32'(cnt_ff) != DEPTH;
   assign out_valid = cnt_ff != '0;
   assign out_data = mem_ff[rd_ff];
   // ==========================================================
   // Pointers and level
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            mem_ff[wr_ff] <= in_data;
            wr_ff <= (32'(wr_ff) == DEPTH - 1) ? '0 : wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= (32'(rd_ff) == DEPTH - 1) ? '0 : rd_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// >>> dca_if.sv
// Link wires between host and device ends.
// Assumes the bench drives only host-side wires; two-way pins resolve from enables.
`timescale 1ns/1ps
interface dca_if;
   logic cs_n;            // Chip select, active low
   logic clk_true;        // bus_clock_true
   logic clk_comp;        // bus_clock_comp
   logic [7:0] h_dq_o;    // Host data out
   logic h_dq_oe;         // Host data enable
   logic [7:0] d_dq_o;    // Device data out
   logic d_dq_oe;         // Device data enable
   logic h_rw_strobe_mask_o;        // Host mask out
   logic h_rw_strobe_mask_oe;       // Host mask enable
   logic d_rw_strobe_mask_o;        // Device strobe out
   logic d_rw_strobe_mask_oe;       // Device strobe enable
   wire [7:0] dq = h_dq_oe ? h_dq_o : (d_dq_oe ? d_dq_o : 8'h00);
   wire rw_strobe_mask = h_rw_strobe_mask_oe ? h_rw_strobe_mask_o : (d_rw_strobe_mask_oe ? d_rw_strobe_mask_o : 1'b0);
   modport host (output cs_n, clk_true, clk_comp, h_dq_o, h_dq_oe,
      h_rw_strobe_mask_o, h_rw_strobe_mask_oe, input dq, rw_strobe_mask);
   modport dev (input cs_n, clk_true, clk_comp, dq, rw_strobe_mask,
      output d_dq_o, d_dq_oe, d_rw_strobe_mask_o, d_rw_strobe_mask_oe);
endinterface

// >>> dca_dev.sv
// Functional notes
// - Host opens with select low, clock idle
// - Header is six bytes on six edges
// - Header bytes sent most significant first
// - Bit 47 one means read
// - Bit 46 selects register space
// - Bit 45 one means linear burst
// - Bits 44..16 give address 31..3
// - Host zeroes unused upper row bits
// - Bits 15..3 reserved, ignored, sent zero
// - Bits 2..0 give starting word
// - Half-page is eight 16-bit words
// - Access timing starts at row capture; the device here counts latency from the last header byte
// - Linear reads prefetch successive half-pages; the device here reads only the next word ahead
// - Host centers header bytes on edges
// - Read data edge-aligned to strobe
// - Transfers are whole 16-bit words only
// - Word address advances once per cycle
// - Array returns bytes in written order
// - Register space words are big-endian
// - Strobe high in header marks extra latency; the device here always drives it low and adds no latency
// - Host ends with select rising
//
// Device end: samples link pins on ref_clk, decodes the header, then
// serves words from a small word memory. Assumes link clock half
// periods of several ref_clk cycles.
`timescale 1ns/1ps
module dca_dev #(
   parameter int MEM_WORDS = 64,
   parameter logic [15:0] ID_WORD = 16'h0c81  // Arbitrary identity value
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Link
   dca_if.dev lnk,
   // Decoded header, user side
   output logic hdr_valid_ff,
   output logic is_read_ff,
   output logic is_reg_ff,
   output logic is_linear_ff,
   output logic [31:0] word_addr_ff,
   output logic refresh_lat_ff
);
   localparam int MA = $clog2(MEM_WORDS);
   // Pin synchronisers; first stage read only by second
   logic cs_m_ff, cs_s_ff, ck_m_ff, ck_s_ff, ck_d_ff;
   logic [7:0] dq_m_ff, dq_s_ff;
   logic rw_m_ff, rw_s_ff;
   dca_pkg::dca_phase_t ph_ff;           // Phase
   logic [2:0] bcnt_ff;                  // Header byte count
   logic [47:0] hdr_ff;                  // Header shift
   logic [7:0] a_ff;                     // Byte A held for pairing
   logic bsel_ff;                        // Second byte of word
   logic [7:0] lat_ff;                   // Access latency counter
   logic [15:0] mem_ff [MEM_WORDS];      // Array words
   logic [15:0] cfg_ff;                  // Register space word
   logic [7:0] dq_o_ff;
   logic dq_oe_ff, rw_o_ff, rw_oe_ff;
   logic [15:0] prefetch_ff;             // Next word, fetched early
   // Edge detection on synchronised clock
   wire edge_any = ck_s_ff ^ ck_d_ff;
   wire edge_rise = ck_s_ff & ~ck_d_ff;
   wire cs_act = ~cs_s_ff;
   wire [47:0] hdr_nxt = {hdr_ff[39:0], dq_s_ff};
   wire [MA-1:0] widx = word_addr_ff[MA-1:0];
   wire [15:0] rd_word = is_reg_ff ? cfg_ff : mem_ff[widx];
   // Next word: wrap inside half-page or run linear
   wire [31:0] addr_inc = is_linear_ff ? word_addr_ff + 32'h1 :
      {word_addr_ff[31:3], word_addr_ff[2:0] + 3'h1};
   assign lnk.d_dq_o = dq_o_ff;
   assign lnk.d_dq_oe = dq_oe_ff;
   assign lnk.d_rw_strobe_mask_o = rw_o_ff;
   assign lnk.d_rw_strobe_mask_oe = rw_oe_ff;
   // ==========================================================
   // Synchronise link pins
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {cs_m_ff, cs_s_ff} <= 2'h3;
         {ck_m_ff, ck_s_ff, ck_d_ff} <= 3'h0;
         {dq_m_ff, dq_s_ff} <= 16'h0;
         {rw_m_ff, rw_s_ff} <= 2'h0;
      end else begin
         cs_m_ff <= lnk.cs_n;
         cs_s_ff <= cs_m_ff;
         ck_m_ff <= lnk.clk_true;
         ck_s_ff <= ck_m_ff;
         ck_d_ff <= ck_s_ff;
         dq_m_ff <= lnk.dq;
         dq_s_ff <= dq_m_ff;
         rw_m_ff <= lnk.rw_strobe_mask;
         rw_s_ff <= rw_m_ff;
      end
   end
   // ==========================================================
   // Transaction phases
   always_ff @(posedge ref_clk) begin
      if (rst || !cs_act) begin
         ph_ff <= dca_pkg::DCA_IDLE;
         bcnt_ff <= 3'h0;
         hdr_ff <= 48'h0;
         bsel_ff <= 1'b0;
         lat_ff <= 8'h0;
         hdr_valid_ff <= 1'b0;
         dq_oe_ff <= 1'b0;
         dq_o_ff <= 8'h00;
         rw_oe_ff <= 1'b0;
         rw_o_ff <= 1'b0;
         a_ff <= 8'h00;
         if (rst) begin
            is_read_ff <= 1'b0;
            is_reg_ff <= 1'b0;
            is_linear_ff <= 1'b0;
            word_addr_ff <= 32'h0;
            refresh_lat_ff <= 1'b0;
            cfg_ff <= ID_WORD;
            prefetch_ff <= 16'h0;
         end
      end else begin
         hdr_valid_ff <= 1'b0;
         case (ph_ff)
            dca_pkg::DCA_IDLE: begin
               // Selected with clock idle low
               ph_ff <= dca_pkg::DCA_HDR;
               rw_oe_ff <= 1'b1;
               rw_o_ff <= refresh_lat_ff;
            end
            dca_pkg::DCA_HDR: begin
               if (edge_any) begin
                  hdr_ff <= hdr_nxt;
                  bcnt_ff <= bcnt_ff + 3'h1;
                  if (bcnt_ff == dca_pkg::HDR_LAST) begin
                     is_read_ff <= hdr_nxt[dca_pkg::BIT_RNW];
                     is_reg_ff <= hdr_nxt[dca_pkg::BIT_SPACE];
                     is_linear_ff <= hdr_nxt[dca_pkg::BIT_BURST];
                     // Reserved 15..3 dropped
                     word_addr_ff <= {hdr_nxt[dca_pkg::ROW_HI:dca_pkg::ROW_LO],
                        hdr_nxt[dca_pkg::COL_HI:dca_pkg::COL_LO]};
                     hdr_valid_ff <= 1'b1;
                     lat_ff <= 8'h0;
                     ph_ff <= dca_pkg::DCA_WAIT;
                     rw_oe_ff <= 1'b0;
                  end
               end
            end
            dca_pkg::DCA_WAIT: begin
               // Count link clocks of access latency
               if (edge_rise) begin
                  lat_ff <= lat_ff + 8'h1;
                  if (32'(lat_ff) == dca_pkg::ACC_CLKS - 1) begin
                     ph_ff <= dca_pkg::DCA_DATA;
                     prefetch_ff <= rd_word;
                     if (is_read_ff) begin
                        dq_oe_ff <= 1'b1;
                        rw_oe_ff <= 1'b1;
                        rw_o_ff <= 1'b0;
                     end
                  end
               end
            end
            dca_pkg::DCA_DATA: begin
               if (edge_any) begin
                  bsel_ff <= ~bsel_ff;
                  if (is_read_ff) begin
                     // Byte A on rising strobe, B on falling
                     rw_o_ff <= ~bsel_ff;
                     // Registers big-endian; array as stored
                     dq_o_ff <= bsel_ff ? prefetch_ff[7:0] :
                        prefetch_ff[15:8];
                     if (bsel_ff) begin
                        word_addr_ff <= addr_inc;
                        // Next word read ahead of its slot
                        prefetch_ff <= is_reg_ff ? cfg_ff :
                           mem_ff[addr_inc[MA-1:0]];
                     end
                  end else begin
                     if (!bsel_ff) begin
                        a_ff <= dq_s_ff;
                     end else begin
                        // Mask high skips the word
                        if (!rw_s_ff) begin
                           if (is_reg_ff) cfg_ff <= {a_ff, dq_s_ff};
                           else mem_ff[widx] <= {a_ff, dq_s_ff};
                        end
                        word_addr_ff <= addr_inc;
                     end
                  end
               end
            end
            default: ph_ff <= dca_pkg::DCA_IDLE;
         endcase
      end
   end
endmodule

// >>> dca_host.sv
// Host end: divides ref_clk into the link clock, sends the header,
// then moves words, writes through a FIFO. Assumes one dca_dev on the link.
`timescale 1ns/1ps
module dca_host #(
   parameter int WORDS = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Request
   input wire logic req_start,
   input wire logic [47:0] req_hdr,
   output logic busy_ff,
   // Write data in
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [15:0] wr_data,
   // Read data out
   output logic rd_valid_ff,
   output logic [15:0] rd_data_ff,
   // Link
   dca_if.host lnk
);
   typedef enum logic [1:0] {DCH_IDLE, DCH_HDR, DCH_WAIT, DCH_DATA} dch_st_t;
   dch_st_t st_ff;
   logic [3:0] div_ff;          // Half period divider
   logic ck_ff, cs_n_ff;
   logic [47:0] sh_ff;          // Header shift
   logic [2:0] n_ff;            // Header bytes sent
   logic [7:0] lat_ff;
   logic [7:0] wcnt_ff;         // Words moved
   logic bsel_ff, rnw_ff;
   logic [7:0] dq_ff, a_ff;
   logic oe_ff;
   logic [1:0] rs_ff;           // Strobe synchroniser
   logic rs_d_ff;
   logic [7:0] dm_ff, ds_ff;    // Data synchroniser
   logic f_valid;
   logic [15:0] f_data;
   localparam int MID_CYC = dca_pkg::LINK_HALF_CYC / 2 - 1;
   wire tick = 32'(div_ff) == dca_pkg::LINK_HALF_CYC - 1;
   // Data launch point, half way between two link clock edges
   wire mid = 32'(div_ff) == MID_CYC;
   // Last half period of the access wait
   wire last_half = 32'(lat_ff) == 2 * dca_pkg::ACC_CLKS - 1;
   // Word leaves the buffer once its B byte has been taken
   wire f_pop = f_valid && st_ff == DCH_DATA && !rnw_ff && tick && !bsel_ff;
   wire strobe_edge = rs_ff[1] ^ rs_d_ff;
   assign lnk.cs_n = cs_n_ff;
   assign lnk.clk_true = ck_ff;
   assign lnk.clk_comp = ~ck_ff;
   assign lnk.h_dq_o = dq_ff;
   assign lnk.h_dq_oe = oe_ff;
   assign lnk.h_rw_strobe_mask_o = 1'b0;
   assign lnk.h_rw_strobe_mask_oe = oe_ff && st_ff == DCH_DATA;
   // Write words buffered so the source sees back-pressure
   dca_fifo #(.WIDTH(16), .DEPTH(4)) u_fifo (
      .ref_clk(ref_clk), .rst(rst),
      .in_valid(wr_valid), .in_ready(wr_ready), .in_data(wr_data),
      .out_valid(f_valid), .out_ready(f_pop), .out_data(f_data));
   // ==========================================================
   // Strobe and data sampling for reads
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rs_ff <= 2'h0;
         rs_d_ff <= 1'b0;
         dm_ff <= 8'h0;
         ds_ff <= 8'h0;
      end else begin
         rs_ff <= {rs_ff[0], lnk.rw_strobe_mask};
         rs_d_ff <= rs_ff[1];
         dm_ff <= lnk.dq;
         ds_ff <= dm_ff;
      end
   end
   // ==========================================================
   // Sequencer
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_ff <= DCH_IDLE;
         div_ff <= 4'h0;
         ck_ff <= 1'b0;
         cs_n_ff <= 1'b1;
         sh_ff <= 48'h0;
         n_ff <= 3'h0;
         lat_ff <= 8'h0;
         wcnt_ff <= 8'h0;
         bsel_ff <= 1'b0;
         rnw_ff <= 1'b0;
         dq_ff <= 8'h0;
         a_ff <= 8'h0;
         oe_ff <= 1'b0;
         busy_ff <= 1'b0;
         rd_valid_ff <= 1'b0;
         rd_data_ff <= 16'h0;
      end else begin
         rd_valid_ff <= 1'b0;
         div_ff <= tick ? 4'h0 : div_ff + 4'h1;
         case (st_ff)
            DCH_IDLE: begin
               ck_ff <= 1'b0;
               if (req_start) begin
                  // Reserved bits forced to zero
                  sh_ff <= {req_hdr[47:16], 13'h0, req_hdr[2:0]};
                  rnw_ff <= req_hdr[dca_pkg::BIT_RNW];
                  cs_n_ff <= 1'b0;
                  busy_ff <= 1'b1;
                  st_ff <= DCH_HDR;
                  n_ff <= 3'h0;
                  oe_ff <= 1'b1;
                  dq_ff <= req_hdr[47:40];
                  div_ff <= 4'h0;
               end
            end
            DCH_HDR: begin
               // Next byte launched mid-half, so it is centered on its edge
               if (mid && n_ff != 3'h0) begin
                  sh_ff <= {sh_ff[39:0], 8'h0};
                  dq_ff <= sh_ff[39:32];
               end
               if (tick) begin
                  ck_ff <= ~ck_ff;
                  n_ff <= n_ff + 3'h1;
                  if (n_ff == dca_pkg::HDR_LAST) begin
                     st_ff <= DCH_WAIT;
                     lat_ff <= 8'h0;
                  end
               end
            end
            DCH_WAIT: begin
               // Release mid-half; last half already shows write byte A
               if (mid) begin
                  oe_ff <= last_half && !rnw_ff;
                  dq_ff <= f_data[15:8];
               end
               if (tick) begin
                  ck_ff <= ~ck_ff;
                  lat_ff <= lat_ff + 8'h1;
                  if (last_half) begin
                     st_ff <= DCH_DATA;
                     wcnt_ff <= 8'h0;
                     bsel_ff <= 1'b0;
                  end
               end
            end
            DCH_DATA: begin
               if (rnw_ff && strobe_edge) begin
                  a_ff <= ds_ff;
                  if (!rs_ff[1]) begin
                     rd_data_ff <= {a_ff, ds_ff};
                     rd_valid_ff <= 1'b1;
                  end
               end
               // Write bytes also launched mid-half
               if (mid && !rnw_ff) begin
                  dq_ff <= bsel_ff ? f_data[15:8] : f_data[7:0];
               end
               if (tick) begin
                  ck_ff <= ~ck_ff;
                  bsel_ff <= ~bsel_ff;
                  if (bsel_ff) wcnt_ff <= wcnt_ff + 8'h1;
                  if (bsel_ff && 32'(wcnt_ff) == WORDS - 1) begin
                     st_ff <= DCH_IDLE;
                     cs_n_ff <= 1'b1;
                     oe_ff <= 1'b0;
                     busy_ff <= 1'b0;
                  end
               end
            end
            default: st_ff <= DCH_IDLE;
         endcase
      end
   end
endmodule

// >>> dca_link_checker.sv
// Concurrent checks on the link wires between host and device ends.
// Assumes one ref_clk domain and rst synchronous, active high.
`timescale 1ns/1ps
module dca_link_checker (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Link wires
   input wire logic cs_n,
   input wire logic clk_true,
   input wire logic clk_comp,
   input wire logic [7:0] dq,
   input wire logic rw_strobe_mask,
   input wire logic h_dq_oe,
   input wire logic d_dq_oe,
   input wire logic d_rw_strobe_mask_oe
);
   // ==========================================================
   // Timing frame
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Select fall, select rise, link clock edge inside a frame
   sequence s_open;
      $fell(cs_n);
   endsequence
   sequence s_close;
      $rose(cs_n);
   endsequence
   sequence s_link_edge;
      !cs_n && $changed(clk_true);
   endsequence
   // ==========================================================
   // Wire rules
   a_open_clk_idle: assert property (s_open |-> !clk_true && clk_comp)
      else $error("link clock not idle at select fall");
   a_clk_pair_inverse: assert property (!cs_n |-> clk_comp != clk_true)
      else $error("clock pair not complementary");
   a_hdr_host_drive: assert property (s_open |-> ##[0:1] h_dq_oe)
      else $error("host not driving header");
   // Each link half period spans six ref cycles
   a_link_half_len: assert property (s_link_edge |=> $stable(clk_true)[*5])
      else $error("link half period too short");
   // Host bytes must not move on a clock edge: centered data
   a_hdr_centered: assert property (s_link_edge and h_dq_oe and $past(h_dq_oe)
      |-> $stable(dq))
      else $error("host byte changed on clock edge");
   a_no_bus_clash: assert property (!(h_dq_oe && d_dq_oe))
      else $error("both ends drive data");
   a_strobe_w_data: assert property (d_dq_oe |-> d_rw_strobe_mask_oe)
      else $error("read data without strobe");
   a_edge_aligned: assert property (d_dq_oe && $past(d_dq_oe) && $changed(dq)
      |-> $changed(rw_strobe_mask))
      else $error("read byte moved without strobe edge");
   a_close_release: assert property (s_close |-> ##[0:4]
      (!h_dq_oe && !d_dq_oe && !d_rw_strobe_mask_oe))
      else $error("pins still driven after select rise");
   a_close_clk_low: assert property (s_close |-> !clk_true)
      else $error("clock not idle at select rise");
endmodule

// >>> tb_ddr_cmd_addr_decode.sv
// Bench: host and device joined on one link, a second device on a
// bench-driven link. Assumes the design files and checker come first.
`timescale 1ns/1ps
module tb_ddr_cmd_addr_decode;
   // ==========================================================
   // Signals
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic req_start = 1'b0;
   logic [47:0] req_hdr = 48'h0;
   logic busy, wr_ready, rd_valid, rlat;
   logic wr_valid = 1'b0;
   logic [15:0] wr_data = 16'h0;
   logic [15:0] rd_data;
   logic hv, is_rd, is_rg, is_ln, hv2, is_rd2, is_rg2, is_ln2;
   logic [31:0] waddr, waddr2;
   logic [34:0] cap, cap2;         // Fields latched at header pulse
   logic [15:0] rdq[$];            // Read words seen by the host
   logic [15:0] wdat[4] = '{16'h1234, 16'hbeef, 16'h0a55, 16'hc3d2};
   localparam logic [15:0] ID_VAL = 16'h5a3c;  // Arbitrary identity
   int num_errors = 0;
   int cmp_count = 0;
   int hv_cnt = 0;
   int hv2_cnt = 0;
   int acc;
   dca_if lnk1 ();
   dca_if lnk2 ();
   // ==========================================================
   // Clock
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // ==========================================================
   // Design ends and checker
   dca_host #(.WORDS(4)) dca_host_i (.ref_clk(ref_clk), .rst(rst),
      .req_start(req_start), .req_hdr(req_hdr), .busy_ff(busy),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
      .rd_valid_ff(rd_valid), .rd_data_ff(rd_data), .lnk(lnk1.host));
   dca_dev #(.ID_WORD(ID_VAL)) dca_dev_i (.ref_clk(ref_clk), .rst(rst),
      .lnk(lnk1.dev), .hdr_valid_ff(hv), .is_read_ff(is_rd),
      .is_reg_ff(is_rg), .is_linear_ff(is_ln), .word_addr_ff(waddr),
      .refresh_lat_ff(rlat));
   // Second device faces the bench, which may break host rules
   dca_dev #(.ID_WORD(ID_VAL)) dca_dev_abort_i (.ref_clk(ref_clk),
      .rst(rst), .lnk(lnk2.dev), .hdr_valid_ff(hv2), .is_read_ff(is_rd2),
      .is_reg_ff(is_rg2), .is_linear_ff(is_ln2), .word_addr_ff(waddr2),
      .refresh_lat_ff());
   dca_link_checker dca_link_checker_i (.ref_clk(ref_clk), .rst(rst),
      .cs_n(lnk1.cs_n), .clk_true(lnk1.clk_true),
      .clk_comp(lnk1.clk_comp), .dq(lnk1.dq), .rw_strobe_mask(lnk1.rw_strobe_mask),
      .h_dq_oe(lnk1.h_dq_oe), .d_dq_oe(lnk1.d_dq_oe),
      .d_rw_strobe_mask_oe(lnk1.d_rw_strobe_mask_oe));
   // ==========================================================
   // Monitors: header pulses and read words
   always @(posedge ref_clk) begin
      if (hv === 1'b1) begin
         hv_cnt++;
         cap = {is_rd, is_rg, is_ln, waddr};
      end
      if (hv2 === 1'b1) begin
         hv2_cnt++;
         cap2 = {is_rd2, is_rg2, is_ln2, waddr2};
      end
      if (rd_valid === 1'b1) begin
         rdq.push_back(rd_data);
      end
   end
   // ==========================================================
   // Tasks
   task test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task check(input string what, input logic [47:0] exp,
      input logic [47:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [47:0] mk(input logic rnw, input logic sp,
      input logic ln, input logic [28:0] up, input logic [2:0] st);
      return {rnw, sp, ln, up, 13'h0, st};
   endfunction
   // One host transaction; bounded wait on busy, then field checks
   task run(input logic [47:0] hdr);
      int i;
      rdq.delete();
      hv_cnt = 0;
      req_hdr <= hdr;
      req_start <= 1'b1;
      @(posedge ref_clk);
      req_start <= 1'b0;
      repeat (2) @(posedge ref_clk);
      for (i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge ref_clk);
      if (i == 2000) begin
         num_errors++;
         test_done();
      end
      repeat (8) @(posedge ref_clk);
      check("header pulses", 48'd1, 48'(hv_cnt));
      // Reserved bits 15..3 are left out of the expectation
      check("fields", 48'({hdr[47:16], hdr[2:0]}), 48'(cap));
   endtask
   // Fill the buffer until it refuses
   task fill();
      acc = 0;
      wr_valid <= 1'b1;
      wr_data <= wdat[0];
      for (int i = 0; i < 12; i++) begin
         @(posedge ref_clk);
         if (wr_ready === 1'b1) acc++;
         wr_data <= wdat[acc % 4];
      end
      wr_valid <= 1'b0;
      check("accepted", 48'd4, 48'(acc));
   endtask
   // Read words against buffer entries picked by index
   task check_rd(input int a, input int b, input int c, input int d);
      logic [15:0] e[4];
      e = '{wdat[a], wdat[b], wdat[c], wdat[d]};
      check("read count", 48'd4, 48'(rdq.size()));
      for (int k = 0; k < 4 && k < rdq.size(); k++) begin
         check("read word", 48'(e[k]), 48'(rdq[k]));
      end
   endtask
   // Bench as host: bytes centered in 62.5 ns half periods
   task link_bytes(input logic [47:0] hdr, input int n);
      lnk2.cs_n <= 1'b0;
      lnk2.h_dq_oe <= 1'b1;
      for (int k = 0; k < n; k++) begin
         lnk2.h_dq_o <= hdr[47 - 8 * k -: 8];
         #31.25;
         lnk2.clk_true <= ~lnk2.clk_true;
         lnk2.clk_comp <= ~lnk2.clk_comp;
         #31.25;
      end
      // Released data out takes the inverse; with enables off the dq line resolves to zero
      lnk2.cs_n <= 1'b1;
      lnk2.h_dq_oe <= 1'b0;
      lnk2.h_dq_o <= ~lnk2.h_dq_o;
      lnk2.clk_true <= 1'b0;
      lnk2.clk_comp <= 1'b1;
      @(posedge ref_clk);
      repeat (20) @(posedge ref_clk);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      lnk2.cs_n = 1'b1;
      lnk2.clk_true = 1'b0;
      lnk2.clk_comp = 1'b1;
      lnk2.h_dq_o = 8'h00;
      lnk2.h_dq_oe = 1'b0;
      lnk2.h_rw_strobe_mask_o = 1'b0;
      lnk2.h_rw_strobe_mask_oe = 1'b0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      fill();
      // Linear array write of words 12..15; upper row bits kept zero
      run(mk(1'b0, 1'b0, 1'b1, 29'd1, 3'd4));
      check("drained", 48'd1, 48'(wr_ready));
      check("refresh flag", 48'd0, 48'(rlat));
      // Linear read from word 4 returns written order
      run(mk(1'b1, 1'b0, 1'b1, 29'd1, 3'd4));
      check_rd(0, 1, 2, 3);
      // Wrapped write from word 6 lands on words 14, 15, 8, 9
      fill();
      run(mk(1'b0, 1'b0, 1'b0, 29'd1, 3'd6));
      // Wrapped read from word 6 with reserved bits set
      run(mk(1'b1, 1'b0, 1'b0, 29'd1, 3'd6) | 48'hfff8);
      check_rd(0, 1, 2, 3);
      // Register space read, identity word first
      run(mk(1'b1, 1'b1, 1'b1, 29'd0, 3'd0));
      check("id word", 48'(ID_VAL), 48'(rdq.size() > 0 ? rdq[0] : 16'h0));
      // Aborted header, then a full one on the bench link
      link_bytes(mk(1'b0, 1'b0, 1'b1, 29'd2, 3'd3), 3);
      check("abort pulses", 48'd0, 48'(hv2_cnt));
      link_bytes(mk(1'b0, 1'b0, 1'b1, 29'd2, 3'd3), 6);
      check("full pulses", 48'd1, 48'(hv2_cnt));
      check("bench fields", 48'({3'h1, 29'd2, 3'd3}), 48'(cap2));
      test_done();
   end
endmodule
